/* File: rtl/spi_master_consts.svh */
`ifndef SPI_MASTER_CONSTS_SVH
`define SPI_MASTER_CONSTS_SVH

// serial word width in bits
`define SPI_WORD_W          16
// fixed divide used while the baud divider field is at or below its low limit
`define SPI_MIN_DIV         8'h04
// baud divider values at or below this use the fixed divide
`define SPI_BRR_LOW_LIMIT   7'h03
// default system clocks per low-speed peripheral clock tick
`define SPI_LSP_DIV_DEFAULT 4
// default transmit buffer depth in words
`define SPI_FIFO_DEPTH_DEF  32

`endif

/* File: rtl/spi_master_pkg.sv */
`include "spi_master_consts.svh"

package spi_master_pkg;

    // one serial word
    typedef logic [`SPI_WORD_W-1:0] word_t;

    // word sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,  // slave select released, clock at rest
        ST_LEAD  = 3'b001,  // select asserted, waiting half a period
        ST_ACT   = 3'b010,  // clock at active level, data just launched
        ST_INACT = 3'b011,  // clock back at rest level, data just sampled
        ST_TRAIL = 3'b100   // last bit sampled, holding select half a period
    } seq_state_t;

    // control bits that configure the link
    typedef struct packed {
        logic       role_master;     // set: this end makes the serial clock
        logic       clock_phase;     // clear: phase-0 timing
        logic       clock_polarity;  // clear: rising edge active
        logic [6:0] baud_divider_field;
    } spi_cfg_t;

    // serial pins driven by the block
    typedef struct packed {
        logic serial_clock_pin;
        logic master_out_line;
        logic slave_select_line_n;
    } spi_pins_t;

    // received word toward the user
    typedef struct packed {
        logic  valid;
        word_t data;
    } rx_word_t;

endpackage

/* File: rtl/word_fifo.sv */
`include "spi_master_consts.svh"

module word_fifo #(
    parameter int WIDTH = `SPI_WORD_W,
    parameter int DEPTH = `SPI_FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // all control state in one word
    typedef struct packed {
        logic [AW-1:0] wr_ptr;  // next slot to fill
        logic [AW-1:0] rd_ptr;  // oldest stored word
        logic [AW:0]   count;   // words held
        logic          full;    // registered so in_ready comes from a flop
    } fifo_state_t;

    fifo_state_t      cur;
    fifo_state_t      next_cur;
    logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed
    logic             push;
    logic             pop;

    assign push      = in_valid && !cur.full;
    assign pop       = out_ready && (cur.count != '0);
    assign in_ready  = !cur.full;
    assign out_valid = (cur.count != '0);
    assign out_data  = mem[cur.rd_ptr];

    // pointer wrap works for any depth, not only powers of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // next-state logic
    always_comb begin
        next_cur = cur;
        if (push) begin
            next_cur.wr_ptr = bump(cur.wr_ptr);
        end
        if (pop) begin
            next_cur.rd_ptr = bump(cur.rd_ptr);
        end
        if (push && !pop) begin
            next_cur.count = cur.count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_cur.count = cur.count - (AW+1)'(1);
        end
        next_cur.full = (next_cur.count == (AW+1)'(DEPTH));
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[cur.wr_ptr] <= in_data;
        end
    end
endmodule // word_fifo

/* File: rtl/spi_master_clocking_framing.sv */
// Notes on behaviour
// - starts only as master with phase bit clear
// - period is peripheral clock over 4 or divider+1
// - odd divide: one half shorter, other longer
// - select asserted half period before first edge
// - select released half period after last sample
// - polarity bit picks rising or falling active edge
// - input sampled on the edge opposite the active
`include "spi_master_consts.svh"

module spi_master_clocking_framing #(
    parameter int LSP_DIV    = `SPI_LSP_DIV_DEFAULT,
    parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // configuration bits
    input  wire spi_master_pkg::spi_cfg_t cfg,
    // transmit words in
    input  wire logic                   tx_valid,
    output logic                        tx_ready,
    input  wire spi_master_pkg::word_t  tx_data,
    // received words out
    output spi_master_pkg::rx_word_t    rx_word,
    output logic                        busy,
    // serial pins
    output spi_master_pkg::spi_pins_t   pins,
    input  wire logic                   master_in_line
);
    // word width shared with the buffer so the shifter and fifo always agree
    localparam int WW = `SPI_WORD_W;

    // all state of the block in one word
    typedef struct packed {
        spi_master_pkg::seq_state_t st;
        logic [7:0]                 lsp_cnt;   // peripheral clock prescaler
        logic [7:0]                 half_cnt;  // peripheral ticks left in this half, less one
        logic [4:0]                 bit_cnt;   // bits sampled so far
        logic [7:0]                 div;       // divide latched for the word
        logic                       pol;       // polarity latched for the word
        spi_master_pkg::word_t      shift;     // tx bits out the top, rx bits in the bottom
        logic                       in_s1;     // synchroniser first stage
        logic                       in_s2;     // synchroniser second stage
        spi_master_pkg::spi_pins_t  pins;
        spi_master_pkg::rx_word_t   rx;
        logic                       busy;
    } core_state_t;

    // registered state and the value it takes at the next edge
    core_state_t           cur;
    core_state_t           next_cur;
    // buffer handshake toward the sequencer
    logic                  word_avail;
    spi_master_pkg::word_t word_head;
    // sequencer side: pop strobe and prescaler tick
    logic                  pop;
    logic                  lsp_tick;
    logic                  fifo_full_n;

    // outputs straight from flops
    assign pins     = cur.pins;
    assign rx_word  = cur.rx;
    assign busy     = cur.busy;

    // buffered ready follows the fifo's registered full flag
    assign tx_ready = fifo_full_n;

    // words wait here until the sequencer is idle; a slow link stalls the filler
    // depth is a parameter; a deeper buffer costs only storage, not timing
    word_fifo #(
        .WIDTH (WW),
        .DEPTH (FIFO_DEPTH)
    ) tx_buffer (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (tx_valid),
        .in_ready  (fifo_full_n),
        .in_data   (tx_data),
        .out_valid (word_avail),
        .out_ready (pop),
        .out_data  (word_head)
    );
    // the fifo registers its full flag, so tx_ready never waits on the sequencer

    // one-cycle enable standing in for the low-speed peripheral clock
    // it runs free, so the lead half may come out up to one tick short;
    // the bit halves are exact because each of them starts on a tick
    assign lsp_tick = (cur.lsp_cnt == 8'h00);

    // a word starts only as master in phase-0 mode; phase-1 is not offered
    // words queued while either bit is wrong simply wait, nothing is dropped
    assign pop = (cur.st == spi_master_pkg::ST_IDLE) && word_avail
               && cfg.role_master && !cfg.clock_phase;

    // divide for a given baud field: fixed 4 at the low end, else field plus one
    function automatic logic [7:0] divide_of(input logic [6:0] brr);
        if (brr <= `SPI_BRR_LOW_LIMIT) begin
            divide_of = `SPI_MIN_DIV;
        end else begin
            // field plus one; the extra top bit keeps the largest divide from wrapping
            divide_of = {1'b0, brr} + 8'h01;
        end
    endfunction

    // active half takes the floor, rest half the ceiling; odd divides split unevenly
    function automatic logic [7:0] short_half(input logic [7:0] d);
        short_half = {1'b0, d[7:1]};
    endfunction

    // rest half, also used for the lead and trail around the word
    function automatic logic [7:0] long_half(input logic [7:0] d);
        long_half = d - {1'b0, d[7:1]};
    endfunction

    // next-state logic
    always_comb begin
        // everything holds unless a branch below says otherwise
        next_cur          = cur;
        // received-word strobe is a one-cycle pulse
        next_cur.rx.valid = 1'b0;
        // input pin passes two flops before the sequencer reads it
        next_cur.in_s1    = master_in_line;
        next_cur.in_s2    = cur.in_s1;
        // prescaler runs free
        if (lsp_tick) begin
            // reload: one tick every LSP_DIV system clocks
            next_cur.lsp_cnt = 8'(LSP_DIV - 1);
        end else begin
            // count down toward the next tick
            next_cur.lsp_cnt = cur.lsp_cnt - 8'h01;
        end

        case (cur.st)
            spi_master_pkg::ST_IDLE: begin
                // clock rests at its polarity level between words
                next_cur.pins.serial_clock_pin    = cfg.clock_polarity;
                next_cur.pins.slave_select_line_n = 1'b1;
                next_cur.busy                     = 1'b0;
                // a word waits, the role is master and the phase is 0
                if (pop) begin
                    // config is latched so a mid-word change cannot tear the clock
                    next_cur.div      = divide_of(cfg.baud_divider_field);
                    next_cur.pol      = cfg.clock_polarity;
                    next_cur.shift    = word_head;
                    next_cur.bit_cnt  = 5'h00;
                    next_cur.half_cnt = long_half(divide_of(cfg.baud_divider_field)) - 8'h01;
                    next_cur.pins.slave_select_line_n = 1'b0;
                    next_cur.busy     = 1'b1;
                    next_cur.st       = spi_master_pkg::ST_LEAD;
                end
            end
            // lead and rest halves end the same way: with an active edge
            spi_master_pkg::ST_LEAD, spi_master_pkg::ST_INACT: begin
                if (lsp_tick) begin
                    if (cur.half_cnt == 8'h00) begin
                        // active edge: clock leaves rest level, next bit goes out
                        next_cur.pins.serial_clock_pin = ~cur.pol;
                        next_cur.pins.master_out_line  = cur.shift[WW-1];
                        next_cur.shift    = {cur.shift[WW-2:0], 1'b0};
                        next_cur.half_cnt = short_half(cur.div) - 8'h01;
                        next_cur.st       = spi_master_pkg::ST_ACT;
                    end else begin
                        // still in the lead or rest half
                        next_cur.half_cnt = cur.half_cnt - 8'h01;
                    end
                end
            end
            // active half: ends at the sampling edge
            spi_master_pkg::ST_ACT: begin
                if (lsp_tick) begin
                    if (cur.half_cnt == 8'h00) begin
                        // opposite edge: clock returns to rest, input bit caught
                        next_cur.pins.serial_clock_pin = cur.pol;
                        next_cur.shift[0] = cur.in_s2;
                        next_cur.bit_cnt  = cur.bit_cnt + 5'h01;
                        next_cur.half_cnt = long_half(cur.div) - 8'h01;
                        // the last sample of the word closes the data phase
                        if (cur.bit_cnt == 5'(WW - 1)) begin
                            next_cur.st = spi_master_pkg::ST_TRAIL;
                        end else begin
                            next_cur.st = spi_master_pkg::ST_INACT;
                        end
                    end else begin
                        // still in the active half
                        next_cur.half_cnt = cur.half_cnt - 8'h01;
                    end
                end
            end
            // trail half: select stays low until it ends
            spi_master_pkg::ST_TRAIL: begin
                if (lsp_tick) begin
                    if (cur.half_cnt == 8'h00) begin
                        // half a period after the last sampling edge
                        next_cur.pins.slave_select_line_n = 1'b1;
                        next_cur.rx.data  = cur.shift;
                        next_cur.rx.valid = 1'b1;
                        next_cur.busy     = 1'b0;
                        next_cur.st       = spi_master_pkg::ST_IDLE;
                    end else begin
                        // select still held after the last sample
                        next_cur.half_cnt = cur.half_cnt - 8'h01;
                    end
                end
            end
            default: begin
                // unused codes fall back to idle instead of locking up
                next_cur.st = spi_master_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // select must leave reset released; everything else clears
            cur                          <= '0;
            cur.pins.slave_select_line_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end
endmodule // spi_master_clocking_framing

/* File: tb/spi_master_checker_props.sv */
`include "spi_master_consts.svh"

module spi_master_checker #(
    parameter int LSP_DIV = 4
) (
    // clock and reset
    input wire logic                      clk,
    input wire logic                      nrst,
    // watched ports
    input wire spi_master_pkg::spi_cfg_t  cfg,
    input wire logic                      busy,
    input wire spi_master_pkg::rx_word_t  rx_word,
    input wire spi_master_pkg::spi_pins_t pins
);
    logic [15:0] cnt;   // length of the clock level just ended
    logic [15:0] sel;   // cycles since select fell
    logic [4:0]  smp;   // rest edges seen in this word
    logic [7:0]  dv;    // divide latched at word start
    logic        pol;   // polarity latched at word start
    logic        ck_q;  // clock one cycle ago
    logic        ss_q;  // select one cycle ago
    wire  [15:0] hs = 16'(dv >> 1) * 16'(LSP_DIV);         // active half in clk
    wire  [15:0] hl = 16'(dv - (dv >> 1)) * 16'(LSP_DIV);  // rest half in clk

    // measure halves and lead; latch the word's setup as select falls
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= '0;
            sel  <= '0;
            smp  <= '0;
            dv   <= 8'h04;
            pol  <= 1'b0;
            ck_q <= 1'b0;
            ss_q <= 1'b1;
        end else begin
            ck_q <= pins.serial_clock_pin;
            ss_q <= pins.slave_select_line_n;
            cnt  <= (pins.serial_clock_pin != ck_q) ? 16'h0001 : cnt + 16'h0001;
            sel  <= pins.slave_select_line_n ? 16'h0000 : sel + 16'h0001;
            if (pins.slave_select_line_n) begin
                smp <= '0;
            end else if (pins.serial_clock_pin != ck_q && pins.serial_clock_pin == pol) begin
                smp <= smp + 5'h01;
            end
            if (ss_q && !pins.slave_select_line_n) begin
                dv  <= (cfg.baud_divider_field <= `SPI_BRR_LOW_LIMIT) ? `SPI_MIN_DIV
                       : {1'b0, cfg.baud_divider_field} + 8'h01;
                pol <= cfg.clock_polarity;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // clock returns to rest inside a word: the sampling edge
    sequence to_rest;
        !pins.slave_select_line_n && $changed(pins.serial_clock_pin) && pins.serial_clock_pin == pol;
    endsequence
    // clock leaves rest inside a word: the launching edge
    sequence to_act;
        !pins.slave_select_line_n && $changed(pins.serial_clock_pin) && pins.serial_clock_pin != pol;
    endsequence

    a_active_half: assert property (to_rest |-> cnt == hs)
        else $error("active clock half has wrong length");
    a_rest_half: assert property (to_act ##0 (smp != 5'h00) |-> cnt == hl)
        else $error("rest clock half has wrong length");
    a_lead_half: assert property (to_act ##0 (smp == 5'h00) |->
        sel >= hl - 16'(LSP_DIV) && sel <= hl + 16'(LSP_DIV))
        else $error("select lead before first edge wrong");
    a_trail_half: assert property ($rose(pins.slave_select_line_n) |->
        cnt == hl && smp == 5'h10)
        else $error("select released at wrong time");
    a_idle_clock: assert property (pins.slave_select_line_n && $past(pins.slave_select_line_n)
        && $past(nrst) |-> pins.serial_clock_pin == $past(cfg.clock_polarity))
        else $error("clock moved outside a word");
    a_data_launch: assert property ($changed(pins.master_out_line)
        && !pins.slave_select_line_n && !$past(pins.slave_select_line_n)
        |-> $changed(pins.serial_clock_pin) && pins.serial_clock_pin != pol)
        else $error("data changed off the active edge");
    a_start_cond: assert property ($rose(busy) |->
        $fell(pins.slave_select_line_n) && $past(cfg.role_master) && !$past(cfg.clock_phase))
        else $error("word started without master phase 0");
    a_no_start: assert property ((!cfg.role_master || cfg.clock_phase)
        && pins.slave_select_line_n |=> pins.slave_select_line_n)
        else $error("select asserted while not allowed");
    a_rx_release: assert property ($rose(pins.slave_select_line_n) |->
        rx_word.valid && !busy ##1 !rx_word.valid)
        else $error("received word not flagged at release");
endmodule // spi_master_checker

bind spi_master_clocking_framing spi_master_checker #(.LSP_DIV(LSP_DIV)) spi_master_checker_inst (
    .clk(clk), .nrst(nrst), .cfg(cfg), .busy(busy), .rx_word(rx_word), .pins(pins)
);

/* File: tb/spi_slave_model.sv */
module spi_slave_model (
    // serial pins from the master
    input wire logic             sclk,
    input wire logic             ss_n,
    input wire logic             mosi,
    input wire logic             pol,
    // reply line and captured word
    output logic                 miso,
    output spi_master_pkg::word_t got
);
    timeunit 1ns;
    timeprecision 1ps;
    spi_master_pkg::word_t sh;            // outgoing shift register
    logic [7:0]            n = 8'h00;     // words served
    logic [4:0]            act = 5'h00;   // active edges in this word
    logic                  ln = 1'b0;     // line level
    assign miso = ln;

    // load the reply as select falls; first bit is on the line at once
    always @(negedge ss_n) begin
        sh = 16'hc3a0 + 16'(n) * 16'h0111;
        n = n + 8'h01;
        act = 5'h00;
        ln = sh[15];
    end
    // a released line shows the inverse so a stale bit never looks valid
    always @(posedge ss_n) ln = ~ln;
    // launch on each active edge after the first, capture on the rest edge
    always @(sclk) begin
        if (!ss_n && sclk != pol) begin
            act = act + 5'h01;
            if (act > 5'h01) begin
                sh = {sh[14:0], 1'b0};
                ln = sh[15];
            end
        end else if (!ss_n) begin
            got = {got[14:0], mosi};
        end
    end
endmodule // spi_slave_model

/* File: tb/test_spi_master_clocking_framing.sv */
module test_spi_master_clocking_framing;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LSP = 3;  // small prescale keeps the run short
    logic                      clk;
    logic                      nrst;
    spi_master_pkg::spi_cfg_t  cfg;
    logic                      tx_valid;
    logic                      tx_ready;
    spi_master_pkg::word_t     tx_data;
    spi_master_pkg::rx_word_t  rx_word;
    logic                      busy;
    spi_master_pkg::spi_pins_t pins;
    logic                      miso;
    spi_master_pkg::word_t     got;
    int                        fails = 0;
    int                        comparisons = 0;
    logic [7:0]                idx = 8'h00;  // words finished
    // polarity and divider per pass; all keep the clock at or below 20 MHz here
    logic                      pols [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [6:0]                brr [5] = '{7'h00, 7'h03, 7'h04, 7'h09, 7'h7f};

    spi_master_clocking_framing #(.LSP_DIV(LSP), .FIFO_DEPTH(32)) spi_master_clocking_framing_inst (
        .clk(clk), .nrst(nrst), .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_word(rx_word), .busy(busy), .pins(pins), .master_in_line(miso)
    );
    spi_slave_model spi_slave_model_inst (
        .sclk(pins.serial_clock_pin), .ss_n(pins.slave_select_line_n),
        .mosi(pins.master_out_line), .pol(cfg.clock_polarity), .miso(miso), .got(got)
    );

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    // offer one word and hold it until the buffer takes it
    task automatic push(input spi_master_pkg::word_t w);
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data  = w;
        while (tx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask

    // wait for a word's release, then compare both directions
    task automatic finish_word(input spi_master_pkg::word_t sent);
        int n;
        n = 0;
        while (rx_word.valid !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check(n < 20000, "word never released");
        check(rx_word.data === 16'hc3a0 + 16'(idx) * 16'h0111, "rx data");
        check(got === sent, "tx data");
        check(busy === 1'b0, "busy at release");
        idx = idx + 8'h01;
        @(negedge clk);
        check(pins.serial_clock_pin === cfg.clock_polarity, "rest level");
    endtask

    // watchdog: far beyond the longest expected run
    initial begin
        #400us;
        $display("MISMATCH %0t watchdog expired", $time);
        fails++;
        summarize();
    end

    initial begin
        nrst = 1'b0;
        cfg = '{role_master: 1'b0, clock_phase: 1'b0, clock_polarity: 1'b0,
                baud_divider_field: 7'h04};
        tx_valid = 1'b0;
        tx_data = '0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        // fill the buffer while not master: nothing may start
        for (int i = 0; i < 32; i++) push(16'h1000 + 16'(i));
        @(negedge clk);
        tx_valid = 1'b0;
        @(negedge clk);
        check(tx_ready === 1'b0, "buffer full refuses");
        check(busy === 1'b0, "started while not master");
        cfg.role_master = 1'b1;
        cfg.clock_phase = 1'b1;
        repeat (20) @(negedge clk);
        check(pins.slave_select_line_n === 1'b1, "started in phase 1");
        cfg.clock_phase = 1'b0;
        // drain back to back at an odd divide
        for (int i = 0; i < 32; i++) finish_word(16'h1000 + 16'(i));
        check(tx_ready === 1'b1, "buffer drained");
        // every divide class, both polarities, two words each
        for (int k = 0; k < 5; k++) begin
            cfg.clock_polarity = pols[k];
            cfg.baud_divider_field = brr[k];
            push(16'h8001 + 16'(k));
            push(16'h7ffe - 16'(k));
            @(negedge clk);
            tx_valid = 1'b0;
            finish_word(16'h8001 + 16'(k));
            finish_word(16'h7ffe - 16'(k));
        end
        summarize();
    end
endmodule // test_spi_master_clocking_framing
